// >>> prs_sequencer.sv
// Behaviour
// - In processor configuration, host reset drops only after supply hold has stayed low over 30 ms; in module configuration, on the request fall.
// - Shutdown disables rails in reverse order of the slot registers as they stand when shutdown starts.
// - Processor configuration debounces power request and hold for 30 ms.
// - Sequence points counted in 64 us steps.
// - Module configuration waits 75 us bias settling before counting steps.
// - Order and step times come from slot registers.
// - Enables issued at slot points without waiting for ramp completion.
// - Default-off rail switched on later is dropped at once on shutdown.
// - End of shutdown restores all registers to power-on defaults.
// - Rail pins OR with serial bits; pin high at start turns on at step 6.
// - Processor shutdown needs power request and hold both low for 30 ms.
// - Host reset asserted when shutdown starts.
// - Module configuration releases host reset 30 ms after enable.
// - Processor startup only if power request still high after debounce.
module prs_sequencer
    import prs_pkg::*;
#(
    parameter int TICK_CYCLES    = STEP_CYCLES,
    parameter int DEB_TICKS      = DEBOUNCE_TICKS,
    parameter int RELEASE_TICKS  = DEBOUNCE_TICKS,
    parameter int BIAS_CYCLES    = BIAS_SETTLE_CYCLES
) (
    // Clock and reset
    input  wire logic                     clock,
    input  wire logic                     rst_n,
    // Host pins
    input  wire prs_pkg::prs_pins_type    pins,
    // Serial register writes
    input  wire prs_pkg::prs_cfg_type     cfg,
    // Rail enables and host reset
    output logic [prs_pkg::RAILS-1:0]     rail_en_reg,
    output logic                          host_reset_n_reg,
    output logic                          seq_idle_reg
);
    import prs_pkg::*;

    typedef enum logic [2:0] {S_OFF, S_BIAS, S_UP, S_IDLE, S_DOWN, S_CLEAR} prs_state_type;

    prs_state_type                state_reg;
    logic                         tick;
    logic                         req_db, hold_db, req_sync;
    logic                         hold_sync, sec_sync, third_sync, prof_sync, cfg_sync;
    logic                         cfg_meta, sec_meta, third_meta, prof_meta;
    logic                         req_prev_reg, pmu_reg, prof_reg;
    logic [SLOT_W-1:0]            slot_reg [RAILS];
    logic [RAILS-1:0]             seq_on_reg, pin_on_reg;
    logic [SLOT_W-1:0]            step_reg;
    logic [15:0]                  bias_reg;
    logic [DEB_CNT_W-1:0]         rel_reg;
    logic                         start_evt, stop_evt, running, pmu_mode;
    logic [RAILS-1:0]             pin_live;

    // Default slot of one rail for the selected profile
    function automatic logic [SLOT_W-1:0] default_slot(input logic prof, input int idx);
        logic [RAILS*SLOT_W-1:0] table_v;
        table_v = prof ? DEFAULT_SLOTS_HIGH : DEFAULT_SLOTS_LOW;
        return table_v[idx*SLOT_W +: SLOT_W];
    endfunction

    // Shared step tick for steps, debounce and reset release (bias wait counts clock cycles); accuracy follows the oscillator
    prs_tick #(.CYCLES(TICK_CYCLES)) u_tick (
        .clock (clock),
        .rst_n (rst_n),
        .tick  (tick)
    );

    // Power request (enable in module configuration) filter
    prs_debounce #(.TICKS(DEB_TICKS)) u_req (
        .clock  (clock),
        .rst_n  (rst_n),
        .raw    (pins.power_request_in),
        .tick   (tick),
        .level  (req_db),
        .synced (req_sync)
    );

    // Supply hold filter
    prs_debounce #(.TICKS(DEB_TICKS)) u_hold (
        .clock  (clock),
        .rst_n  (rst_n),
        .raw    (pins.supply_hold_in),
        .tick   (tick),
        .level  (hold_db),
        .synced (hold_sync)
    );

    // Remaining pins through two flops each
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            {cfg_meta, sec_meta, third_meta, prof_meta} <= 4'h0;
            {cfg_sync, sec_sync, third_sync, prof_sync} <= 4'h0;
        end else begin
            {cfg_meta, sec_meta, third_meta, prof_meta} <= {pins.pmu_config, pins.second_converter_pin,
                                                             pins.third_linear_pin, pins.default_profile_select};
            {cfg_sync, sec_sync, third_sync, prof_sync} <= {cfg_meta, sec_meta, third_meta, prof_meta};
        end
    end

    assign pin_live = {1'b0, third_sync, sec_sync, 1'b0} & PIN_RAILS;
    assign running  = (state_reg == S_BIAS) || (state_reg == S_UP) || (state_reg == S_IDLE);

    // Strap read straight from its synchroniser while off; a request arriving with it must not be judged in the old mode
    assign pmu_mode = (state_reg == S_OFF) ? cfg_sync : pmu_reg;

    // Start and stop conditions per configuration
    always_comb begin
        if (pmu_mode) begin
            start_evt = req_db;
            stop_evt  = !req_db && !hold_db;
        end else begin
            start_evt = req_sync && !req_prev_reg;
            stop_evt  = !req_sync && req_prev_reg;
        end
    end

    // Enable edge memory and strap capture while off
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            req_prev_reg <= 1'b0;
            pmu_reg      <= 1'b0;
            prof_reg     <= 1'b0;
        end else begin
            req_prev_reg <= req_sync;
            if (state_reg == S_OFF) begin
                pmu_reg  <= cfg_sync;
                prof_reg <= prof_sync;
            end
        end
    end

    // Main sequence state
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= S_OFF;
        end else begin
            unique case (state_reg)
                S_OFF:   if (start_evt) state_reg <= pmu_mode ? S_UP : S_BIAS;
                S_BIAS:  if (stop_evt) state_reg <= S_DOWN;
                         else if (bias_reg == 16'(BIAS_CYCLES - 1)) state_reg <= S_UP;
                S_UP:    if (stop_evt) state_reg <= S_DOWN;
                         else if (tick && step_reg == SLOT_LAST) state_reg <= S_IDLE;
                S_IDLE:  if (stop_evt) state_reg <= S_DOWN;
                S_DOWN:  if (tick && step_reg == SLOT_OFF) state_reg <= S_CLEAR;
                S_CLEAR: state_reg <= S_OFF;
            endcase
        end
    end

    // Bias settle counter, cycles of the system clock
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            bias_reg <= '0;
        end else if (state_reg == S_BIAS) begin
            bias_reg <= bias_reg + 1'b1;
        end else begin
            bias_reg <= '0;
        end
    end

    // Step counter: up during startup, down from the last slot in shutdown
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            step_reg <= SLOT_OFF;
        end else if (running && stop_evt) begin
            step_reg <= SLOT_LAST;
        end else if (state_reg == S_UP && tick) begin
            step_reg <= step_reg + 1'b1;
        end else if (state_reg == S_DOWN && tick) begin
            step_reg <= step_reg - 1'b1;
        end else if (state_reg == S_OFF) begin
            step_reg <= SLOT_OFF;
        end
    end

    // Slot registers: serial writes, restored to defaults after shutdown
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < RAILS; i++) slot_reg[i] <= default_slot(1'b0, i);
        end else if (state_reg == S_CLEAR) begin
            for (int i = 0; i < RAILS; i++) slot_reg[i] <= default_slot(prof_reg, i);
        end else if (state_reg == S_OFF && start_evt) begin
            for (int i = 0; i < RAILS; i++) slot_reg[i] <= default_slot(prof_sync, i);
        end else if (cfg.write && state_reg == S_IDLE) begin
            slot_reg[cfg.rail] <= cfg.slot;
        end
    end

    // Sequenced rail enables; issued at slot points, ramp not awaited
    // The last step is kept out of the slot match, else the wrap to 0 would switch default-off rails on
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            seq_on_reg <= '0;
        end else begin
            for (int i = 0; i < RAILS; i++) begin
                if (running && stop_evt && slot_reg[i] == SLOT_OFF) begin
                    seq_on_reg[i] <= 1'b0;
                end else if (state_reg == S_UP && tick && step_reg != SLOT_LAST && slot_reg[i] == step_reg + 1'b1) begin
                    seq_on_reg[i] <= 1'b1;
                end else if (state_reg == S_DOWN && tick && slot_reg[i] == step_reg) begin
                    seq_on_reg[i] <= 1'b0;
                end else if (state_reg == S_IDLE && cfg.write && cfg.rail == RAIL_W'(i)) begin
                    seq_on_reg[i] <= cfg.on;
                end else if (state_reg == S_CLEAR) begin
                    seq_on_reg[i] <= 1'b0;
                end
            end
        end
    end

    // Pin-driven enables: armed at step 6, follow the pin while idle
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            pin_on_reg <= '0;
        end else if (state_reg == S_UP && tick && step_reg + 1'b1 == PIN_SLOT) begin
            pin_on_reg <= pin_live;
        end else if (state_reg == S_IDLE) begin
            pin_on_reg <= pin_live;
        end else if (state_reg == S_DOWN && tick && step_reg == PIN_SLOT) begin
            pin_on_reg <= '0;
        end else if (state_reg == S_OFF) begin
            pin_on_reg <= '0;
        end
    end

    // Outputs straight from flops; one cycle behind the enable state
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            rail_en_reg  <= '0;
            seq_idle_reg <= 1'b0;
        end else begin
            rail_en_reg  <= seq_on_reg | pin_on_reg;
            seq_idle_reg <= (state_reg == S_IDLE);
        end
    end

    // Host reset: released a debounce time after start, dropped at shutdown
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            host_reset_n_reg <= 1'b0;
            rel_reg          <= '0;
        end else if (!running || stop_evt) begin
            host_reset_n_reg <= 1'b0;
            rel_reg          <= '0;
        end else if (!host_reset_n_reg && tick) begin
            if (rel_reg == DEB_CNT_W'(RELEASE_TICKS - 1)) begin
                host_reset_n_reg <= 1'b1;
            end else begin
                rel_reg <= rel_reg + 1'b1;
            end
        end
    end

    // Checks
    sequence s_stop_run;
        running && stop_evt;
    endsequence

    sequence s_down_entry;
        state_reg == S_DOWN && step_reg == SLOT_LAST;
    endsequence

    AST_RESET_ON_STOP: assert property (@(posedge clock) disable iff (!rst_n)
        s_stop_run |=> !host_reset_n_reg ##1 !host_reset_n_reg)
        else $error("host reset not asserted at shutdown start");

    AST_STOP_ENTERS_DOWN: assert property (@(posedge clock) disable iff (!rst_n)
        s_stop_run |=> s_down_entry)
        else $error("shutdown did not start at last slot");

    AST_PMU_STOP_NEEDS_BOTH: assert property (@(posedge clock) disable iff (!rst_n)
        pmu_reg && running ##1 state_reg == S_DOWN |-> $past(!req_db && !hold_db))
        else $error("processor shutdown without both inputs low");

    AST_PMU_START_DEBOUNCED: assert property (@(posedge clock) disable iff (!rst_n)
        state_reg == S_OFF && pmu_mode ##1 state_reg == S_UP |-> $past(req_db))
        else $error("processor startup without debounced request");

    AST_BIAS_WAIT: assert property (@(posedge clock) disable iff (!rst_n)
        state_reg == S_BIAS ##1 state_reg == S_UP |-> $past(bias_reg) == 16'(BIAS_CYCLES - 1))
        else $error("steps started before bias settled");

    AST_UP_AT_SLOT: assert property (@(posedge clock) disable iff (!rst_n)
        state_reg == S_UP && !stop_evt && $rose(seq_on_reg[0]) |-> $past(slot_reg[0]) == $past(step_reg) + 1'b1)
        else $error("rail enabled away from its slot");

    AST_DOWN_AT_SLOT: assert property (@(posedge clock) disable iff (!rst_n)
        $past(state_reg) == S_DOWN && $fell(seq_on_reg[0]) |-> $past(tick) && $past(slot_reg[0]) == $past(step_reg))
        else $error("rail disabled away from its slot");

    AST_OFF_DEFAULT_DROP: assert property (@(posedge clock) disable iff (!rst_n)
        s_stop_run and (slot_reg[2] == SLOT_OFF) |=> !seq_on_reg[2] ##1 rail_en_reg[2] == $past(pin_on_reg[2]))
        else $error("default-off rail not dropped at once");

    AST_NO_ENABLE_AT_END: assert property (@(posedge clock) disable iff (!rst_n)
        state_reg == S_UP && !stop_evt && tick && step_reg == SLOT_LAST |=> seq_on_reg == $past(seq_on_reg))
        else $error("rail enabled at end of startup");

    AST_CLEAR_DEFAULTS: assert property (@(posedge clock) disable iff (!rst_n)
        state_reg == S_CLEAR |=> slot_reg[1] == default_slot(prof_reg, 1) && seq_on_reg == '0)
        else $error("registers not restored after shutdown");

    AST_RELEASE_TIME: assert property (@(posedge clock) disable iff (!rst_n)
        $rose(host_reset_n_reg) |-> $past(rel_reg) == DEB_CNT_W'(RELEASE_TICKS - 1) && $past(tick))
        else $error("host reset released at wrong time");

    AST_STEP_ON_TICK: assert property (@(posedge clock) disable iff (!rst_n)
        state_reg == S_UP && !stop_evt && !tick |=> $stable(step_reg))
        else $error("step counter moved without tick");

    AST_PIN_AT_SIX: assert property (@(posedge clock) disable iff (!rst_n)
        state_reg == S_UP && $rose(pin_on_reg[1]) |-> $past(step_reg) + 1'b1 == PIN_SLOT)
        else $error("pin rail enabled away from step 6");

endmodule

// >>> prs_pkg.sv
package prs_pkg;

    // Rails under sequencer control
    localparam int RAILS = 4;
    localparam int SLOT_W = 4;
    localparam int RAIL_W = 2;

    // Rail indices
    localparam logic [RAIL_W-1:0] RAIL_STEP_DOWN_ONE = 2'h0;
    localparam logic [RAIL_W-1:0] RAIL_STEP_DOWN_TWO = 2'h1;
    localparam logic [RAIL_W-1:0] RAIL_THIRD_LINEAR  = 2'h2;
    localparam logic [RAIL_W-1:0] RAIL_LOW_INPUT_ONE = 2'h3;

    // Sequence slots: 0 means off by default, the last slot ends the sequence
    localparam logic [SLOT_W-1:0] SLOT_OFF  = 4'h0;
    localparam logic [SLOT_W-1:0] SLOT_LAST = 4'hf;
    localparam logic [SLOT_W-1:0] PIN_SLOT  = 4'h6;

    // Pin-enabled rails
    localparam logic [RAILS-1:0] PIN_RAILS = 4'h6;

    // Power-on default slots, rail 0 in the low nibble
    localparam logic [RAILS*SLOT_W-1:0] DEFAULT_SLOTS_HIGH = 16'h3021;
    localparam logic [RAILS*SLOT_W-1:0] DEFAULT_SLOTS_LOW  = 16'h2411;

    // Timing
    localparam int CLOCK_MHZ         = 100;
    localparam int STEP_US           = 64;
    localparam int DEBOUNCE_MS       = 30;
    localparam int BIAS_SETTLE_NS    = 75000;
    localparam int STEP_CYCLES       = STEP_US * CLOCK_MHZ;
    localparam int DEBOUNCE_TICKS    = (DEBOUNCE_MS * 1000 + STEP_US - 1) / STEP_US;
    localparam int BIAS_SETTLE_CYCLES = (BIAS_SETTLE_NS * CLOCK_MHZ + 999) / 1000;
    localparam int TICK_CNT_W        = 16;
    localparam int DEB_CNT_W         = 12;

    // Pins from the host
    typedef struct packed {
        logic power_request_in;
        logic supply_hold_in;
        logic second_converter_pin;
        logic third_linear_pin;
        logic default_profile_select;
        logic pmu_config;
    } prs_pins_type;

    // Register write from the serial interface logic
    typedef struct packed {
        logic              write;
        logic [RAIL_W-1:0] rail;
        logic [SLOT_W-1:0] slot;
        logic              on;
    } prs_cfg_type;

endpackage

// >>> prs_tick.sv
module prs_tick #(
    parameter int CYCLES = prs_pkg::STEP_CYCLES
) (
    // Clock and reset
    input  wire logic clock,
    input  wire logic rst_n,
    // Step tick
    output logic      tick
);
    import prs_pkg::*;

    logic [TICK_CNT_W-1:0] count_reg;

    // Free-running divider; one pulse per step interval
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            count_reg <= '0;
            tick      <= 1'b0;
        end else if (count_reg == TICK_CNT_W'(CYCLES - 1)) begin
            count_reg <= '0;
            tick      <= 1'b1;
        end else begin
            count_reg <= count_reg + 1'b1;
            tick      <= 1'b0;
        end
    end

endmodule

// >>> prs_debounce.sv
module prs_debounce #(
    parameter int TICKS = prs_pkg::DEBOUNCE_TICKS
) (
    // Clock and reset
    input  wire logic clock,
    input  wire logic rst_n,
    // Pin and shared tick
    input  wire logic raw,
    input  wire logic tick,
    // Filtered level and synchronised copy
    output logic      level,
    output logic      synced
);
    import prs_pkg::*;

    logic                 meta_reg;
    logic [DEB_CNT_W-1:0] count_reg;

    // Two-stage synchroniser; only the second stage is read
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            meta_reg <= 1'b0;
            synced   <= 1'b0;
        end else begin
            meta_reg <= raw;
            synced   <= meta_reg;
        end
    end

    // Accept a change only once it has held for the full tick count
    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            count_reg <= '0;
            level     <= 1'b0;
        end else if (synced == level) begin
            count_reg <= '0;
        end else if (tick) begin
            if (count_reg == DEB_CNT_W'(TICKS - 1)) begin
                level     <= synced;
                count_reg <= '0;
            end else begin
                count_reg <= count_reg + 1'b1;
            end
        end
    end

endmodule

// >>> prs_host_model.sv
module prs_host_model
    import prs_pkg::*;
(
    // Host intent from the bench
    input  wire logic             want_power,
    input  wire logic             want_hold,
    input  wire logic             want_second,
    input  wire logic             want_third,
    input  wire logic             want_profile,
    input  wire logic             want_proc,
    // Pins towards the sequencer
    output prs_pkg::prs_pins_type pins
);
    timeunit 1ns;
    timeprecision 1ns;

    // Pins follow the intent at once; the bench moves it on the falling edge, so no race with a sampling flop
    assign pins.power_request_in       = want_power;
    assign pins.supply_hold_in         = want_hold;
    assign pins.second_converter_pin   = want_second;
    assign pins.third_linear_pin       = want_third;
    assign pins.default_profile_select = want_profile;
    assign pins.pmu_config             = want_proc;
endmodule

// >>> tb_top.sv
`define check_eq(act, exp, msg) begin \
    checks++; \
    if ((act) !== (exp)) begin \
        fails++; \
        $display("wrong value at %0t: %s", $time, msg); \
    end \
end

module tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import prs_pkg::*;

    // Shortened counts so the run stays brief
    localparam int TICK = 8;
    localparam int DEB  = 3;
    localparam int REL  = 3;
    localparam int BIAS = 20;

    logic                  clock = 1'b0;
    logic                  rst_n = 1'b0;
    logic                  want_power = 1'b0;
    logic                  want_hold = 1'b0;
    logic                  want_second = 1'b0;
    logic                  want_third = 1'b0;
    logic                  want_profile = 1'b0;
    logic                  want_proc = 1'b0;
    prs_pins_type          pins;
    prs_cfg_type           cfg = '0;
    logic [RAILS-1:0]      rail_en;
    logic                  host_reset_n;
    logic                  seq_idle;
    int                    fails = 0;
    int                    checks = 0;
    int                    first;
    int                    cyc;

    prs_host_model prs_host_model_inst (
        .want_power   (want_power),
        .want_hold    (want_hold),
        .want_second  (want_second),
        .want_third   (want_third),
        .want_profile (want_profile),
        .want_proc    (want_proc),
        .pins         (pins)
    );

    prs_sequencer #(
        .TICK_CYCLES   (TICK),
        .DEB_TICKS     (DEB),
        .RELEASE_TICKS (REL),
        .BIAS_CYCLES   (BIAS)
    ) prs_sequencer_inst (
        .clock            (clock),
        .rst_n            (rst_n),
        .pins             (pins),
        .cfg              (cfg),
        .rail_en_reg      (rail_en),
        .host_reset_n_reg (host_reset_n),
        .seq_idle_reg     (seq_idle)
    );

    // Free-running 100 MHz clock
    initial begin
        forever #5 clock = ~clock;
    end

    // Follow n rail changes; each must land on the listed state, spaced as listed (0 = any)
    task automatic follow(input int n, input logic [3:0] st [4], input int gap [4], output int first_cyc);
        int c;
        logic [3:0] prev;
        for (int i = 0; i < n; i++) begin
            prev = rail_en;
            c = 0;
            do begin
                @(negedge clock);
                c++;
            end while (rail_en === prev && c < 3000);
            `check_eq(rail_en, st[i], "rail enables out of order")
            if (gap[i] != 0) `check_eq(c, gap[i], "step spacing")
            if (i == 0) first_cyc = c;
        end
    endtask

    // Bounded wait for normal operation
    task automatic wait_idle();
        int c;
        c = 0;
        while (seq_idle !== 1'b1 && c < 400) begin
            @(negedge clock);
            c++;
        end
        `check_eq(seq_idle, 1'b1, "sequence never reached normal operation")
        `check_eq(host_reset_n, 1'b1, "host reset still held")
    endtask

    // One serial register write, a single-cycle pulse
    task automatic write_slot(input logic [RAIL_W-1:0] r, input logic [SLOT_W-1:0] s, input logic o);
        @(negedge clock);
        cfg = '{1'b1, r, s, o};
        @(negedge clock);
        cfg.write = 1'b0;
    endtask

    // Count cycles from now until the host reset drops
    task automatic time_reset_drop(output int c);
        c = 0;
        while (host_reset_n !== 1'b0 && c < 200) begin
            @(negedge clock);
            c++;
        end
    endtask

    // Module start with the low profile: bias wait, then slots 1,1 / 2 / 4, reset released
    task automatic s_module_start();
        int t;
        @(negedge clock);
        want_profile = 1'b0;
        want_power = 1'b1;
        t = 0;
        while (host_reset_n !== 1'b1 && t < 200) begin
            @(negedge clock);
            t++;
        end
        `check_eq((t >= (REL - 1) * TICK + 2) && (t <= REL * TICK + 8), 1'b1, "host reset release time")
        follow(2, '{4'h3, 4'hb, 4'h0, 4'h0}, '{0, TICK, 0, 0}, first);
        `check_eq(first + t > BIAS, 1'b1, "rails enabled before bias settled")
        follow(1, '{4'hf, 4'h0, 4'h0, 4'h0}, '{2 * TICK, 0, 0, 0}, first);
        wait_idle();
    endtask

    // Module stop: reset asserted first, then slots counted downward
    task automatic s_module_stop(input logic [3:0] st [4], input int gap [4]);
        @(negedge clock);
        want_power = 1'b0;
        time_reset_drop(cyc);
        `check_eq(rail_en, 4'hf, "rails dropped before host reset")
        follow(3, st, gap, first);
        `check_eq(seq_idle, 1'b0, "still idle after shutdown")
        repeat (3 * TICK) @(negedge clock);
    endtask

    // High profile with the third-rail pin high: pin rail joins at step 6, leaves at step 6
    task automatic s_pin_rails();
        @(negedge clock);
        want_profile = 1'b1;
        want_third = 1'b1;
        want_second = 1'b1;
        want_power = 1'b1;
        follow(4, '{4'h1, 4'h3, 4'hb, 4'hf}, '{0, TICK, TICK, 3 * TICK}, first);
        wait_idle();
        @(negedge clock);
        want_power = 1'b0;
        follow(2, '{4'hb, 4'h3, 4'h0, 4'h0}, '{0, 3 * TICK, 0, 0}, first);
        want_third = 1'b0;
        want_second = 1'b0;
        repeat (4 * TICK) @(negedge clock);
    endtask

    // Default-off rail switched on serially is dropped at once on the enable fall
    task automatic s_late_rail();
        @(negedge clock);
        want_power = 1'b1;
        follow(3, '{4'h1, 4'h3, 4'hb, 4'h0}, '{0, TICK, TICK, 0}, first);
        wait_idle();
        `check_eq(rail_en, 4'hb, "default-off rail enabled by startup")
        write_slot(RAIL_THIRD_LINEAR, SLOT_OFF, 1'b1);
        repeat (2) @(negedge clock);
        `check_eq(rail_en, 4'hf, "serial enable ignored")
        @(negedge clock);
        want_power = 1'b0;
        follow(4, '{4'hb, 4'h3, 4'h1, 4'h0}, '{0, 0, TICK, TICK}, first);
        `check_eq(first <= 8, 1'b1, "serially enabled rail not dropped at once")
        repeat (3 * TICK) @(negedge clock);
    endtask

    // Processor configuration: short request refused, both inputs must fall to stop
    task automatic s_processor();
        @(negedge clock);
        want_proc = 1'b1;
        want_profile = 1'b0;
        want_hold = 1'b1;
        want_power = 1'b1;
        repeat (10) @(negedge clock);
        want_power = 1'b0;
        repeat (150) @(negedge clock);
        `check_eq(rail_en, 4'h0, "short request started the rails")
        want_power = 1'b1;
        follow(3, '{4'h3, 4'hb, 4'hf, 4'h0}, '{0, TICK, 2 * TICK, 0}, first);
        `check_eq(first > (DEB - 1) * TICK, 1'b1, "start before debounce")
        wait_idle();
        want_power = 1'b0;
        repeat (150) @(negedge clock);
        `check_eq(host_reset_n, 1'b1, "stop with supply hold still high")
        want_hold = 1'b0;
        time_reset_drop(cyc);
        `check_eq(cyc > (DEB - 1) * TICK, 1'b1, "host reset dropped before hold debounce")
        `check_eq(rail_en, 4'hf, "rails dropped before host reset")
        follow(3, '{4'hb, 4'h3, 4'h0, 4'h0}, '{0, 2 * TICK, TICK, 0}, first);
        repeat (3 * TICK) @(negedge clock);
    endtask

    // Counts, verdict and end of run
    task automatic print_verdict();
        $display("checks %0d, mismatches %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        repeat (5) @(negedge clock);
        rst_n = 1'b1;
        repeat (3) @(negedge clock);
        `check_eq(rail_en, 4'h0, "rails on after reset")
        s_module_start();
        s_module_stop('{4'hb, 4'h3, 4'h0, 4'h0}, '{0, 2 * TICK, TICK, 0});
        s_module_start();
        write_slot(RAIL_LOW_INPUT_ONE, 4'h5, 1'b1);
        s_module_stop('{4'h7, 4'h3, 4'h0, 4'h0}, '{0, TICK, 3 * TICK, 0});
        s_module_start();
        s_module_stop('{4'hb, 4'h3, 4'h0, 4'h0}, '{0, 2 * TICK, TICK, 0});
        s_pin_rails();
        s_late_rail();
        s_processor();
        print_verdict();
    end

    // Watchdog: the whole run needs a few thousand cycles
    initial begin
        #200000;
        fails++;
        print_verdict();
    end
endmodule
